// [core/smpm_top.sv]
// Purpose: strap-selected and cycle-multiplexed pin functions
// Assumes: all pin inputs synchronous to clk_sys
// Notes: pin drives are registered, so a pin follows its cause one
//   edge later; two-way pins are split into in, out and enable
`timescale 1ns/1ps
`default_nettype none
`include "smpm_defs.svh"
// Summary of operation
// RULE_01: straps at power-on fix shared pin functions
// RULE_02: straps 00 desktop, low-only nb1, high-only nb2
// RULE_03: parity lines desktop, power inputs in notebook
// RULE_04: nb1 rising-edge irq1, else bus io check
// RULE_05: management irq0 event on every rising edge
// RULE_06: suspend/resume request on button rising edge
// RULE_07: notebook stop-grant low output, desktop int_request_13
// RULE_08: notebook suspended low output, desktop int_request_15
// RULE_09: nb1 dma acks 0/5, else ack codes
// RULE_10: notebook power outputs replace desktop functions
// RULE_11: tag data in cache cycles, dram address in dram cycles
// RULE_12: address bit 10 or dirty bit
// RULE_13: bus cycle rom enable and keyboard select
// RULE_14: bus cycle clock-chip strobe and write
// RULE_15: disk command block select for both ranges
// RULE_16: disk control block select for both ranges
// RULE_17: bus cycle disk transceiver byte enables
// RULE_18: pin 8 pulses low on index 24h write
// RULE_19: pin 9 asserts on index 21h read
// RULE_20: dirty write-back or tag write enable output
// RULE_21: active-low sram output and write enables
// RULE_22: toggled address bits 2 and 3 outputs
// RULE_23: tag pin function follows cycle; idle undriven
// RULE_24: strap captured at reset release, then frozen
module smpm_top
  import smpm_pkg::*;
#(
  parameter int TAG_W = `SMPM_TAG_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_strap_low,
  input wire logic mode_strap_high,
  input wire smpm_cycle_e cycleType,
  input wire logic [`SMPM_SP_N-1:0] sharedPinIn,
  output logic [`SMPM_SP_N-1:0] sharedPinOut,
  output logic [`SMPM_SP_N-1:0] sharedPinOe,
  input wire logic [TAG_W:0] tagPinIn,
  output logic [TAG_W:0] tagPinOut,
  output logic [TAG_W:0] tagPinOe,
  input wire logic [3:0] parityOut,
  input wire logic [3:0] parityOe,
  input wire logic stopGrantCycle,
  input wire logic suspended,
  input wire logic dmaAck0,
  input wire logic dmaAck5,
  input wire logic [2:0] dmaAckCode,
  input wire logic [7:0] powerCtl,
  input wire logic cacheWrEnBankB,
  input wire logic cacheOutEnBankB,
  input wire logic memdataLatch,
  input wire logic [TAG_W-1:0] tagWrData,
  input wire logic dirtyWrData,
  input wire logic tagDrive,
  input wire logic [TAG_W:0] dramAddr,
  input wire smpm_bus_s busCtl,
  input wire smpm_cfg_s cfgAccess,
  input wire logic dirtyWrite,
  input wire logic sramOe,
  input wire logic sramWe,
  input wire logic [1:0] toggledAddr,
  input wire logic ext_mgmt_irq_in0,
  input wire logic suspend_resume_button,
  output smpm_mode_e mode,
  output logic modeValid,
  output logic [3:0] parityIn,
  output smpm_pm_s pmStatus,
  output logic busIoCheck,
  output logic intRequest13,
  output logic intRequest15,
  output logic [3:0] dmaRequest,
  output logic [TAG_W-1:0] tagRdData,
  output logic dirtyRdData,
  output logic mgmtIrq0Event,
  output logic mgmtIrq1Event,
  output logic suspendResumeEvent,
  output logic dirty_write_en_n,
  output logic sram_output_en_n,
  output logic sram_write_en_n,
  output logic toggled_addr_bit2,
  output logic toggled_addr_bit3
);

  logic isDesk;
  logic isNb1;
  logic captured_r;
  logic [`SMPM_SP_N-1:0] spOut_nxt;
  logic [`SMPM_SP_N-1:0] spOe_nxt;
  logic [TAG_W:0] tpOut_nxt;
  logic [TAG_W:0] tpOe_nxt;
  logic [TAG_W-1:0] busPin_n;
  logic [2:0] rise;

  if (TAG_W != `SMPM_TAG_W) begin : g_chk
    $error("smpm_top serves exactly ten tag pins plus bit 10");
  end

  assign isDesk = (mode == SMPM_MD_DESK);
  assign isNb1 = (mode == SMPM_MD_NB1);
  assign modeValid = captured_r;

  // strap caught on the first edge after reset release, never again;
  // an illegal strap of both high falls back to desktop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= SMPM_MD_DESK;
      captured_r <= 1'b0;
    end else if (!captured_r) begin // RULE_24
      captured_r <= 1'b1;
      case ({mode_strap_high, mode_strap_low}) // RULE_01
        `SMPM_STRAP_DESK: mode <= SMPM_MD_DESK; // RULE_02
        `SMPM_STRAP_NB1: mode <= SMPM_MD_NB1; // RULE_02
        `SMPM_STRAP_NB2: mode <= SMPM_MD_NB2; // RULE_02
        default: mode <= SMPM_MD_DESK;
      endcase
    end
  end

  // shared pin drive by mode; an input function leaves the driver off
  always_comb begin
    spOut_nxt = '0;
    spOe_nxt = '0;
    if (isDesk) begin
      spOut_nxt[`SMPM_SP_PARITY_LINE_3:`SMPM_SP_PARITY_LINE_0] = parityOut; // RULE_03
      spOe_nxt[`SMPM_SP_PARITY_LINE_3:`SMPM_SP_PARITY_LINE_0] = parityOe; // RULE_03
      spOut_nxt[`SMPM_SP_PWR0] = cacheWrEnBankB; // RULE_10
      spOut_nxt[`SMPM_SP_PWR1] = cacheOutEnBankB; // RULE_10
      spOut_nxt[`SMPM_SP_PWR2] = memdataLatch; // RULE_10
    end else begin
      spOut_nxt[`SMPM_SP_STOP_GRANT_OUT_N] = ~stopGrantCycle; // RULE_07
      spOe_nxt[`SMPM_SP_STOP_GRANT_OUT_N] = 1'b1; // RULE_07
      spOut_nxt[`SMPM_SP_SUSP] = ~suspended; // RULE_08
      spOe_nxt[`SMPM_SP_SUSP] = 1'b1; // RULE_08
      spOut_nxt[`SMPM_SP_PWR2:`SMPM_SP_PWR0] = powerCtl[2:0]; // RULE_10
    end
    spOe_nxt[`SMPM_SP_PWR2:`SMPM_SP_PWR0] = 3'h7;
    if (isNb1) begin
      spOut_nxt[`SMPM_SP_DMA_ACK_0] = dmaAck0; // RULE_09
      spOut_nxt[`SMPM_SP_DMA_ACK_5] = dmaAck5; // RULE_09
      spOut_nxt[`SMPM_SP_PWR7:`SMPM_SP_PWR3] = powerCtl[7:3]; // RULE_10
      spOe_nxt[`SMPM_SP_PWR7:`SMPM_SP_PWR3] = 5'h1f; // RULE_10
    end else begin
      spOut_nxt[`SMPM_SP_DMA_ACK_0] = dmaAckCode[0]; // RULE_09
      spOut_nxt[`SMPM_SP_DMA_ACK_5] = dmaAckCode[1]; // RULE_09
      spOut_nxt[`SMPM_SP_PWR3] = dmaAckCode[2]; // RULE_10
      spOe_nxt[`SMPM_SP_PWR3] = 1'b1;
    end
    spOe_nxt[`SMPM_SP_DMA_ACK_5:`SMPM_SP_DMA_ACK_0] = 2'h3;
  end

  // shared pin drivers, off until the strap is known
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sharedPinOut <= '0;
      sharedPinOe <= '0;
    end else begin
      sharedPinOut <= spOut_nxt;
      sharedPinOe <= captured_r ? spOe_nxt : '0;
    end
  end

  // inputs returned to the core; the unused mode reads as idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      parityIn <= '0;
      pmStatus <= smpm_pm_s'(`SMPM_PM_IDLE);
      busIoCheck <= 1'b0;
      intRequest13 <= 1'b0;
      intRequest15 <= 1'b0;
      dmaRequest <= '0;
    end else begin
      parityIn <= isDesk ? sharedPinIn[`SMPM_SP_PARITY_LINE_3:`SMPM_SP_PARITY_LINE_0]
                         : 4'h0; // RULE_03
      // pin 0 carries mains, pin 3 the event; the struct is msb first
      pmStatus <= isDesk ? smpm_pm_s'(`SMPM_PM_IDLE) // RULE_03
                         : smpm_pm_s'({sharedPinIn[`SMPM_SP_PARITY_LINE_0],
                             sharedPinIn[`SMPM_SP_PAR1],
                             sharedPinIn[`SMPM_SP_PAR2],
                             sharedPinIn[`SMPM_SP_PARITY_LINE_3]});
      busIoCheck <= !isNb1 && sharedPinIn[`SMPM_SP_IRQ1]; // RULE_04
      intRequest13 <= isDesk && sharedPinIn[`SMPM_SP_STOP_GRANT_OUT_N]; // RULE_07
      intRequest15 <= isDesk && sharedPinIn[`SMPM_SP_SUSP]; // RULE_08
      dmaRequest <= isNb1 ? 4'h0
                          : sharedPinIn[`SMPM_SP_PWR7:`SMPM_SP_PWR4];
    end
  end

  // edge events: irq0, button, and the shared irq1 pin
  smpm_edge_det #(
    .WIDTH(3)
  ) u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .level({sharedPinIn[`SMPM_SP_IRQ1], suspend_resume_button,
            ext_mgmt_irq_in0}),
    .rise(rise)
  );

  assign mgmtIrq0Event = rise[0]; // RULE_05
  assign suspendResumeEvent = rise[1]; // RULE_06
  // gated by mode after detection so the strap capture makes no edge
  assign mgmtIrq1Event = rise[2] & isNb1; // RULE_04

  smpm_bus_decode #(
    .PINS(TAG_W)
  ) u_bus (
    .busCtl(busCtl),
    .cfgAccess(cfgAccess),
    .busPin_n(busPin_n)
  );

  // tag/address pin function follows the cycle that owns it
  always_comb begin
    tpOut_nxt = '0;
    tpOe_nxt = '0;
    case (cycleType) // RULE_23
      SMPM_CY_CACHE: begin
        tpOut_nxt = {dirtyWrData, tagWrData}; // RULE_11
        tpOe_nxt = {(TAG_W+1){tagDrive}}; // RULE_12
      end
      SMPM_CY_DRAM: begin
        tpOut_nxt = dramAddr; // RULE_11
        tpOe_nxt = '1; // RULE_12
      end
      SMPM_CY_BUS: begin
        tpOut_nxt = {1'b0, busPin_n}; // RULE_13
        tpOe_nxt = {1'b0, {TAG_W{1'b1}}};
      end
      default: begin
        tpOut_nxt = '0;
        tpOe_nxt = '0;
      end
    endcase
  end

  // tag pin drivers and captured tag read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tagPinOut <= '0;
      tagPinOe <= '0;
      tagRdData <= '0;
      dirtyRdData <= 1'b0;
    end else begin
      tagPinOut <= tpOut_nxt;
      tagPinOe <= tpOe_nxt;
      if (cycleType == SMPM_CY_CACHE && !tagDrive) begin
        tagRdData <= tagPinIn[TAG_W-1:0]; // RULE_11
        dirtyRdData <= tagPinIn[TAG_W]; // RULE_12
      end
    end
  end

  // dedicated cache pins, all registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dirty_write_en_n <= `SMPM_STRB_IDLE;
      sram_output_en_n <= `SMPM_STRB_IDLE;
      sram_write_en_n <= `SMPM_STRB_IDLE;
      toggled_addr_bit2 <= 1'b0;
      toggled_addr_bit3 <= 1'b0;
    end else begin
      dirty_write_en_n <= ~dirtyWrite; // RULE_20
      sram_output_en_n <= ~sramOe; // RULE_21
      sram_write_en_n <= ~sramWe; // RULE_21
      toggled_addr_bit2 <= toggledAddr[0]; // RULE_22
      toggled_addr_bit3 <= toggledAddr[1]; // RULE_22
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  mode_frozen_a: assert property (captured_r |=> $stable(mode)) // RULE_24
    else $error("mode changed after capture");
  strap_nb1_a: assert property ($rose(captured_r) && // RULE_02
    $past(mode_strap_low) && !$past(mode_strap_high) |-> isNb1)
    else $error("strap 01 did not select notebook mode 1");
  par_input_a: assert property (captured_r && !isDesk |=> // RULE_03
    sharedPinOe[`SMPM_SP_PARITY_LINE_3:`SMPM_SP_PARITY_LINE_0] == 4'h0)
    else $error("power input pins driven in notebook mode");
  stop_grant_a: assert property (captured_r && !isDesk && // RULE_07
    stopGrantCycle |=> sharedPinOe[`SMPM_SP_STOP_GRANT_OUT_N] &&
    !sharedPinOut[`SMPM_SP_STOP_GRANT_OUT_N])
    else $error("stop grant not driven low");
  int_request_15_in_a: assert property (captured_r && isDesk |=> // RULE_08
    !sharedPinOe[`SMPM_SP_SUSP])
    else $error("interrupt 15 pin driven in desktop mode");
  pwr_hi_a: assert property (captured_r && isNb1 |=> // RULE_10
    sharedPinOut[`SMPM_SP_PWR7:`SMPM_SP_PWR3] == $past(powerCtl[7:3]))
    else $error("power outputs 3 to 7 wrong in notebook mode 1");
  tag_idle_a: assert property (cycleType == SMPM_CY_IDLE |=> // RULE_23
    tagPinOe == '0)
    else $error("tag pins driven with no owning cycle");
  dram_addr_a: assert property (cycleType == SMPM_CY_DRAM |=> // RULE_11
    tagPinOut == $past(dramAddr) && &tagPinOe)
    else $error("dram address not on tag pins");
  cfg_wr_a: assert property (cycleType == SMPM_CY_BUS && // RULE_18
    cfgAccess.write && cfgAccess.index == `SMPM_CFG_WR_IDX |=>
    !tagPinOut[`SMPM_TP_CFGW] ##1 (tagPinOut[`SMPM_TP_CFGW] ||
    $past(cycleType != SMPM_CY_BUS ||
    (cfgAccess.write && cfgAccess.index == `SMPM_CFG_WR_IDX))))
    else $error("config write pulse missing");
  irq0_edge_a: assert property ($rose(ext_mgmt_irq_in0) |=> // RULE_05
    mgmtIrq0Event ##1 !mgmtIrq0Event)
    else $error("irq0 edge not a one-cycle event");
  button_a: assert property (suspendResumeEvent |-> // RULE_06
    $past(suspend_resume_button) && !$past(suspend_resume_button, 2))
    else $error("button event without a rise");

  nb1_c: cover property ($rose(captured_r) ##1 isNb1);
  bus_cfg_rd_c: cover property (cycleType == SMPM_CY_BUS &&
    cfgAccess.read ##1 !tagPinOut[`SMPM_TP_CFGR]);
  dram_c: cover property (cycleType == SMPM_CY_DRAM ##1 &tagPinOe);
  button_c: cover property (suspendResumeEvent);

endmodule
`default_nettype wire

// [core/smpm_defs.svh]
// Purpose: named constants for the strap mode pin multiplexer
// Assumes: included by bare name after the package
// Notes: definitions only
`ifndef SMPM_DEFS_SVH
`define SMPM_DEFS_SVH

// strap codes as {mode_strap_high, mode_strap_low}
`define SMPM_STRAP_DESK 2'h0
`define SMPM_STRAP_NB1 2'h1
`define SMPM_STRAP_NB2 2'h2

// widths
`define SMPM_TAG_W 10
`define SMPM_IO_W 10
`define SMPM_SP_N 17

// shared pin slots
`define SMPM_SP_PARITY_LINE_0 0
`define SMPM_SP_PAR1 1
`define SMPM_SP_PAR2 2
`define SMPM_SP_PARITY_LINE_3 3
`define SMPM_SP_IRQ1 4
`define SMPM_SP_STOP_GRANT_OUT_N 5
`define SMPM_SP_SUSP 6
`define SMPM_SP_DMA_ACK_0 7
`define SMPM_SP_DMA_ACK_5 8
`define SMPM_SP_PWR0 9
`define SMPM_SP_PWR1 10
`define SMPM_SP_PWR2 11
`define SMPM_SP_PWR3 12
`define SMPM_SP_PWR4 13
`define SMPM_SP_PWR7 16

// tag/address pin slots in bus cycles
`define SMPM_TP_ROM 0
`define SMPM_TP_KBD 1
`define SMPM_TP_CLOCK_CHIP_STROBE_N 2
`define SMPM_TP_CLOCK_CHIP_WRITE_N 3
`define SMPM_TP_CMD 4
`define SMPM_TP_CTL 5
`define SMPM_TP_XH 6
`define SMPM_TP_XL 7
`define SMPM_TP_CFGW 8
`define SMPM_TP_CFGR 9

// i/o decode ranges, base and number of ignored low bits
`define SMPM_CMD_PRI 10'h1f0
`define SMPM_CMD_SEC 10'h170
`define SMPM_CMD_LOW 3
`define SMPM_CTL_PRI 10'h3f6
`define SMPM_CTL_SEC 10'h376
`define SMPM_CTL_LOW 1
`define SMPM_CFG_WR_IDX 8'h24
`define SMPM_CFG_RD_IDX 8'h21

// reset values
`define SMPM_EDGE_PREV_RST 1'h1
`define SMPM_STRB_IDLE 1'h1
// power inputs seen in desktop mode: only the low-true event idles high
`define SMPM_PM_IDLE 4'h1

`endif

// [core/smpm_pkg.sv]
// Purpose: types shared by the strap mode pin multiplexer
// Assumes: nothing
// Notes: constants live in smpm_defs.svh
package smpm_pkg;

  // operating mode fixed by the power-on strap
  typedef enum logic [2:0] {
    SMPM_MD_DESK = 3'b001,
    SMPM_MD_NB1 = 3'b010,
    SMPM_MD_NB2 = 3'b100
  } smpm_mode_e;

  // cycle that owns the tag/address pins
  typedef enum logic [3:0] {
    SMPM_CY_IDLE = 4'b0001,
    SMPM_CY_CACHE = 4'b0010,
    SMPM_CY_DRAM = 4'b0100,
    SMPM_CY_BUS = 4'b1000
  } smpm_cycle_e;

  // expansion-bus cycle controls, all active high
  typedef struct packed {
    logic ioCycle;
    logic [9:0] ioAddr;
    logic romRead;
    logic kbdSelect;
    logic rtcStrobe;
    logic rtcWrite;
    logic xcvrHigh;
    logic xcvrLow;
  } smpm_bus_s;

  // configuration register access strobes
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] index;
  } smpm_cfg_s;

  // notebook power-management inputs
  typedef struct packed {
    logic mainsPresent;
    logic alarm;
    logic batteryLow;
    logic externalEvent_n;
  } smpm_pm_s;

endpackage

// [core/smpm_edge_det.sv]
// Purpose: rising-edge event detector for event pins
// Assumes: inputs synchronous to clk_sys
// Notes: one-cycle pulse one edge after the rise
`timescale 1ns/1ps
`default_nettype none
`include "smpm_defs.svh"
module smpm_edge_det #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] prev_r;

  if (WIDTH < 1) begin : g_chk
    $error("smpm_edge_det needs WIDTH of at least one");
  end

  // previous level resets high so a pin held high at power-on is no event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_r <= {WIDTH{`SMPM_EDGE_PREV_RST}};
    end else begin
      prev_r <= level;
    end
  end

  // pulse on each low-to-high transition
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise <= '0;
    end else begin
      rise <= level & ~prev_r;
    end
  end

endmodule
`default_nettype wire

// [core/smpm_bus_decode.sv]
// Purpose: expansion-bus cycle functions of the tag/address pins
// Assumes: inputs valid for the whole bus cycle
// Notes: combinational, active-low result; caller registers it
`timescale 1ns/1ps
`default_nettype none
`include "smpm_defs.svh"
module smpm_bus_decode
  import smpm_pkg::*;
#(
  parameter int PINS = `SMPM_TAG_W
) (
  input wire smpm_bus_s busCtl,
  input wire smpm_cfg_s cfgAccess,
  output logic [PINS-1:0] busPin_n
);

  if (PINS < `SMPM_TAG_W) begin : g_chk
    $error("smpm_bus_decode needs ten bus-cycle pins");
  end

  // address falls in an aligned window above the ignored low bits
  function automatic logic inRange(input logic [9:0] addr,
                                   input logic [9:0] base,
                                   input int lowBits);
    inRange = (addr >> lowBits) == (base >> lowBits);
  endfunction

  logic cmdHit;
  logic ctlHit;

  // disk chip selects for either controller channel
  assign cmdHit = busCtl.ioCycle &
    (inRange(busCtl.ioAddr, `SMPM_CMD_PRI, `SMPM_CMD_LOW) |
     inRange(busCtl.ioAddr, `SMPM_CMD_SEC, `SMPM_CMD_LOW)); // RULE_15
  assign ctlHit = busCtl.ioCycle &
    (inRange(busCtl.ioAddr, `SMPM_CTL_PRI, `SMPM_CTL_LOW) |
     inRange(busCtl.ioAddr, `SMPM_CTL_SEC, `SMPM_CTL_LOW)); // RULE_16

  // every bus-cycle function is active low; unused upper pins stay high
  always_comb begin
    busPin_n = '1;
    busPin_n[`SMPM_TP_ROM] = ~busCtl.romRead; // RULE_13
    busPin_n[`SMPM_TP_KBD] = ~busCtl.kbdSelect; // RULE_13
    busPin_n[`SMPM_TP_CLOCK_CHIP_STROBE_N] = ~busCtl.rtcStrobe; // RULE_14
    busPin_n[`SMPM_TP_CLOCK_CHIP_WRITE_N] = ~busCtl.rtcWrite; // RULE_14
    busPin_n[`SMPM_TP_CMD] = ~cmdHit; // RULE_15
    busPin_n[`SMPM_TP_CTL] = ~ctlHit; // RULE_16
    busPin_n[`SMPM_TP_XH] = ~busCtl.xcvrHigh; // RULE_17
    busPin_n[`SMPM_TP_XL] = ~busCtl.xcvrLow; // RULE_17
    busPin_n[`SMPM_TP_CFGW] = ~(cfgAccess.write &
      (cfgAccess.index == `SMPM_CFG_WR_IDX)); // RULE_18
    busPin_n[`SMPM_TP_CFGR] = ~(cfgAccess.read &
      (cfgAccess.index == `SMPM_CFG_RD_IDX)); // RULE_19
  end

endmodule
`default_nettype wire

// [bench/smpm_pin_partner.sv]
// Purpose: board side of the shared and tag/address pins
// Assumes: bench supplies what outside parts drive on released pins
// Notes: a released pin shows the outside part, never the last drive
`timescale 1ns/1ps
`default_nettype none
`include "smpm_defs.svh"
module smpm_pin_partner (
  input wire logic [`SMPM_SP_N-1:0] sharedPinOut,
  input wire logic [`SMPM_SP_N-1:0] sharedPinOe,
  input wire logic [`SMPM_SP_N-1:0] extShared,
  input wire logic [10:0] tagPinOut,
  input wire logic [10:0] tagPinOe,
  input wire logic [10:0] extTag,
  output logic [`SMPM_SP_N-1:0] sharedPinIn,
  output logic [10:0] tagPinIn
);
  // wire level: the chip wins where it drives, else the outside part
  // the outside value changes every cycle, so a stale drive never hides
  assign sharedPinIn = (sharedPinOut & sharedPinOe) |
    (extShared & ~sharedPinOe);
  assign tagPinIn = (tagPinOut & tagPinOe) | (extTag & ~tagPinOe);
endmodule
`default_nettype wire

// [bench/tb.sv]
// Purpose: self-checking bench for the strap mode pin multiplexer
// Assumes: clk_sys at 40 MHz, rst held three cycles per strap value
// Notes: random traffic from an xorshift source, checked every edge
`timescale 1ns/1ps
`default_nettype none
`include "smpm_defs.svh"
module tb;
  import smpm_pkg::*;
  logic clk_sys, rst, mode_strap_low, mode_strap_high;
  smpm_cycle_e cycleType;
  logic [16:0] sharedPinIn, sharedPinOut, sharedPinOe, extShared;
  logic [10:0] tagPinIn, tagPinOut, tagPinOe, extTag, dramAddr;
  logic [3:0] parityOut, parityOe, parityIn, dmaRequest;
  logic stopGrantCycle, suspended, dmaAck0, dmaAck5, cacheWrEnBankB;
  logic cacheOutEnBankB, memdataLatch, dirtyWrData, tagDrive, dirtyWrite;
  logic sramOe, sramWe, ext_mgmt_irq_in0, suspend_resume_button;
  logic modeValid, busIoCheck, intRequest13, intRequest15, dirtyRdData;
  logic mgmtIrq0Event, mgmtIrq1Event, suspendResumeEvent;
  logic dirty_write_en_n, sram_output_en_n, sram_write_en_n;
  logic toggled_addr_bit2, toggled_addr_bit3;
  logic [2:0] dmaAckCode, eEv;
  logic [7:0] powerCtl;
  logic [9:0] tagWrData, tagRdData;
  logic [1:0] toggledAddr;
  smpm_bus_s busCtl;
  smpm_cfg_s cfgAccess;
  smpm_mode_e mode;
  smpm_pm_s pmStatus;
  int bad_count, checked, k, md;
  logic [31:0] seed;
  logic pIrq0, pSr, pIo;
  logic [10:0] rdM, eTpOut, eTpOe;
  logic [16:0] eSpOut, eSpOe;
  logic [14:0] eIn;
  logic [4:0] eDed;
  smpm_mode_e mdTab [3];
  logic [9:0] baseTab [4];

  smpm_top i_dut (.*);
  smpm_pin_partner i_pins (.*);

  // free-running system clock
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string nm, input logic [16:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pin data only matters where the pin is driven
  task automatic cmpPin(input string nm, input logic [16:0] eo, ee, go, ge);
    cmp({nm, "Oe"}, ee, ge);
    cmp(nm, eo & ee, go & ee);
  endtask

  // new random inputs; addresses and indexes lean on the decode edges
  task automatic drive();
    logic [63:0] r;
    logic [31:0] a;
    r = {rnd(), rnd()};
    {mode_strap_low, mode_strap_high, stopGrantCycle, suspended, dmaAck0,
     dmaAck5, cacheWrEnBankB, cacheOutEnBankB, memdataLatch, dirtyWrData,
     tagDrive, dirtyWrite, sramOe, sramWe, ext_mgmt_irq_in0,
     suspend_resume_button, dmaAckCode, toggledAddr, parityOut, parityOe,
     powerCtl, tagWrData, dramAddr} = r[57:0];
    r = {rnd(), rnd()};
    {extShared, extTag, busCtl, cfgAccess} = r[54:0];
    a = rnd();
    cycleType = smpm_cycle_e'(4'h1 << a[1:0]);
    busCtl.ioAddr = a[2] ? a[12:3] : baseTab[a[4:3]] + 10'(a[8:5]);
    cfgAccess.index = a[13] ? a[21:14] : (a[14] ? 8'h24 : 8'h21);
  endtask

  // bench model: what every output must show after this edge
  task automatic predict();
    logic nb, n1;
    if (k == 1) md = (mode_strap_high & mode_strap_low) ? 0 :
      int'({mode_strap_high, mode_strap_low});
    nb = md != 0;
    n1 = md == 1;
    eSpOut = 17'h0;
    eSpOe = 17'h0;
    if (nb) begin
      eSpOut[6:5] = {~suspended, ~stopGrantCycle};
      eSpOe[6:5] = 2'h3;
    end else begin
      eSpOut[3:0] = parityOut;
      eSpOe[3:0] = parityOe;
    end
    eSpOe[12:7] = 6'h3f;
    eSpOut[8:7] = n1 ? {dmaAck5, dmaAck0} : dmaAckCode[1:0];
    eSpOut[11:9] = nb ? powerCtl[2:0] :
      {memdataLatch, cacheOutEnBankB, cacheWrEnBankB};
    eSpOut[12] = n1 ? powerCtl[3] : dmaAckCode[2];
    if (n1) begin
      eSpOut[16:13] = powerCtl[7:4];
      eSpOe[16:13] = 4'hf;
    end
    eIn = {nb ? 4'h0 : sharedPinIn[3:0], nb ? {sharedPinIn[0],
      sharedPinIn[1], sharedPinIn[2], sharedPinIn[3]} : 4'h1,
      !n1 && sharedPinIn[4], !nb && sharedPinIn[5], !nb && sharedPinIn[6],
      n1 ? 4'h0 : sharedPinIn[16:13]};
    eEv = {ext_mgmt_irq_in0 & ~pIrq0, n1 & sharedPinIn[4] & ~pIo,
      suspend_resume_button & ~pSr};
    {pIrq0, pIo, pSr} = {ext_mgmt_irq_in0, sharedPinIn[4],
      suspend_resume_button};
    eDed = {~dirtyWrite, ~sramOe, ~sramWe, toggledAddr};
    eTpOut = 11'h0;
    eTpOe = 11'h0;
    case (cycleType)
      SMPM_CY_CACHE: begin
        eTpOut = {dirtyWrData, tagWrData};
        eTpOe = {11{tagDrive}};
        if (!tagDrive) rdM = tagPinIn;
      end
      SMPM_CY_DRAM: begin
        eTpOut = dramAddr;
        eTpOe = 11'h7ff;
      end
      SMPM_CY_BUS: begin
        eTpOe = 11'h3ff;
        eTpOut = {1'h0, ~{cfgAccess.read && cfgAccess.index == 8'h21,
          cfgAccess.write && cfgAccess.index == 8'h24, busCtl.xcvrLow,
          busCtl.xcvrHigh, busCtl.ioCycle && (busCtl.ioAddr inside
          {[10'h3f6:10'h3f7], [10'h376:10'h377]}), busCtl.ioCycle &&
          (busCtl.ioAddr inside {[10'h1f0:10'h1f7], [10'h170:10'h177]}),
          busCtl.rtcWrite, busCtl.rtcStrobe, busCtl.kbdSelect,
          busCtl.romRead}};
      end
      default: ;
    endcase
  endtask

  task automatic check();
    cmpPin("shared", eSpOut, eSpOe, sharedPinOut, sharedPinOe);
    cmpPin("tag", 17'(eTpOut), 17'(eTpOe),
      17'(tagPinOut), 17'(tagPinOe));
    cmp("inputs", 17'(eIn), 17'({parityIn, pmStatus, busIoCheck,
      intRequest13, intRequest15, dmaRequest}));
    cmp("events", 17'(eEv), 17'({mgmtIrq0Event, mgmtIrq1Event,
      suspendResumeEvent}));
    cmp("readback", 17'(rdM), 17'({dirtyRdData, tagRdData}));
    cmp("cache", 17'(eDed), 17'({dirty_write_en_n, sram_output_en_n,
      sram_write_en_n, toggled_addr_bit3, toggled_addr_bit2}));
  endtask

  // one edge: predict from what the edge sees, compare, then drive
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      k++;
      predict();
      #1;
      cmp("mode", 17'({modeValid, mode}), 17'({1'h1, mdTab[md]}));
      if (k >= 2) check();
      #1;
      drive();
    end
  endtask

  // reset with a strap; 11 is refused and reads as desktop
  task automatic doReset(input logic [1:0] s);
    rst = 1'h1;
    {mode_strap_high, mode_strap_low} = s;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp("rstState", 17'h0071, 17'({modeValid, mgmtIrq0Event, mgmtIrq1Event,
      suspendResumeEvent, |{sharedPinOe, tagPinOe}, dirty_write_en_n,
      sram_output_en_n, sram_write_en_n, pmStatus}));
    #1;
    rst = 1'h0;
    k = 0;
    {pIrq0, pIo, pSr} = 3'h7;
    rdM = 11'h0;
  endtask

  task automatic end_sim();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence: every strap value, later ones reset in mid-run
  initial begin
    mdTab = '{SMPM_MD_DESK, SMPM_MD_NB1, SMPM_MD_NB2};
    baseTab = '{10'h1f0, 10'h170, 10'h3f6, 10'h376};
    bad_count = 0;
    checked = 0;
    k = 0;
    md = 0;
    seed = 32'hed68;
    rst = 1'h1;
    drive();
    for (int m = 0; m < 4; m++) begin
      doReset(2'(m));
      step(500);
    end
    end_sim();
  end

  // hang guard, far above the planned run length
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
